// ==== rtl/rcsf_pkg.sv ====
// Register map, field positions and reset values of the reset-cause status block
package rcsf_pkg;

    // Byte offsets on the register bus
    localparam logic [15:0] OFF_RESET_CAUSE = 16'h0000;
    localparam logic [15:0] OFF_INT_STATUS = 16'h0004;
    localparam logic [15:0] OFF_INT_MASK = 16'h0008;

    // Field positions of reset_cause_control
    localparam int unsigned BIT_TRAP_CONFLICT = 15;
    localparam int unsigned BIT_ILLEGAL_INSTR = 14;
    localparam int unsigned BIT_SW_BROWNOUT_EN = 13;
    localparam int unsigned BIT_RETENTION_SLEEP = 12;
    localparam int unsigned BIT_CONFIG_MISMATCH = 9;
    localparam int unsigned BIT_PROGMEM_SLEEP = 8;
    localparam int unsigned BIT_EXT_PIN_RESET = 7;
    localparam int unsigned BIT_SW_RESET_INSTR = 6;
    localparam int unsigned BIT_SW_WATCHDOG_EN = 5;
    localparam int unsigned BIT_WATCHDOG_TIMEOUT = 4;
    localparam int unsigned BIT_SLEEP_WAKE = 3;
    localparam int unsigned BIT_IDLE_WAKE = 2;
    localparam int unsigned BIT_BROWNOUT = 1;
    localparam int unsigned BIT_POWER_ON = 0;

    localparam int unsigned REG_W = 16;

    // Power-on value: brown-out and power-on flags both set
    localparam logic [15:0] RESET_CAUSE_RST = 16'h0003;
    // Bits 11 and 10 are unimplemented and never store a one
    localparam logic [15:0] RESET_CAUSE_WMASK = 16'hF3FF;
    // Bits that hardware events can raise, also the interrupt layout
    localparam logic [15:0] EVENT_BITS = 16'hC2DE;

    localparam logic [15:0] INT_STATUS_RST = 16'h0000;
    localparam logic [15:0] INT_MASK_RST = 16'h0000;

    // Watchdog configuration field value when left unprogrammed
    localparam logic [1:0] WDT_CFG_UNPROGRAMMED = 2'h3;
    // Watchdog enable after reset, matching an unprogrammed field
    localparam logic WDT_EN_RST = 1'b1;

endpackage

// ==== rtl/rcsf_sync.sv ====
// Two-stage synchroniser for a pin with a falling-edge pulse
`timescale 1ns/10ps
module rcsf_sync #(
    parameter logic IDLE_LEVEL = 1'b1
) (
    input wire logic clk,   // System clock
    input wire logic rstn,  // Asynchronous reset, active low
    input wire logic pin,   // Asynchronous pin level
    output logic level,     // Synchronised level
    output logic fall       // One-cycle pulse on a high-to-low change
);

    logic meta_q;
    logic meta_d;
    logic sync_q;
    logic sync_d;
    logic prev_q;
    logic prev_d;

    always_comb
    begin
        meta_d = pin;
        sync_d = meta_q;
        prev_d = sync_q;
    end

    // Resets to the idle level so release of reset fakes no edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= IDLE_LEVEL;
            sync_q <= IDLE_LEVEL;
            prev_q <= IDLE_LEVEL;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    assign level = sync_q;
    assign fall = prev_q & ~sync_q;

endmodule

// ==== rtl/rcsf_irq.sv ====
// Sticky interrupt status with read-to-clear, mask and one level output
`timescale 1ns/10ps
module rcsf_irq #(
    parameter int unsigned W = 16
) (
    input wire logic clk,             // System clock
    input wire logic rstn,            // Asynchronous reset, active low
    input wire logic [W-1:0] evt,     // Event pulses, one bit per source
    input wire logic [W-1:0] rd_clr,  // Bits to clear after a status read
    input wire logic mask_we,         // Mask write strobe
    input wire logic [W-1:0] mask_wd, // Next mask value when strobed
    output logic [W-1:0] status,      // Sticky status
    output logic [W-1:0] mask,        // Mask, one enables the source
    output logic irq                  // Level interrupt
);

    logic [W-1:0] status_q;
    logic [W-1:0] status_d;
    logic [W-1:0] mask_q;
    logic [W-1:0] mask_d;
    logic irq_q;
    logic irq_d;

    // Elaboration check on the width
    if (W < 1 || W > 32)
    begin
        $error("rcsf_irq: width out of range");
    end

    always_comb
    begin
        // A new event wins over the clear of the same bit
        status_d = (status_q & ~rd_clr) | evt;
        mask_d = mask_we ? mask_wd : mask_q;
        irq_d = |(status_d & mask_d);
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            status_q <= W'(rcsf_pkg::INT_STATUS_RST);
            mask_q <= W'(rcsf_pkg::INT_MASK_RST);
            irq_q <= 1'b0;
        end
        else
        begin
            status_q <= status_d;
            mask_q <= mask_d;
            irq_q <= irq_d;
        end
    end

    assign status = status_q;
    assign mask = mask_q;
    assign irq = irq_q;

endmodule

// ==== rtl/rcsf_top.sv ====
// Reset-cause status register with APB access and event interrupt
`timescale 1ns/10ps
module rcsf_top #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic clk,                        // System clock, 25 MHz
    input wire logic rstn,                       // Power-on reset, async, active low
    input wire logic psel,                       // APB select
    input wire logic penable,                    // APB access phase
    input wire logic pwrite,                     // APB direction, high for write
    input wire logic [ADDR_W-1:0] paddr,         // APB byte address
    input wire logic [31:0] pwdata,              // APB write data
    input wire logic [3:0] pstrb,                // APB write byte strobes
    output logic [31:0] prdata,                  // APB read data
    output logic pready,                         // APB ready
    output logic pslverr,                        // APB error, unmapped address
    input wire logic trap_conflict_evt,          // Trap conflict event pulse
    input wire logic illegal_instr_evt,          // Illegal opcode or bad pointer pulse
    input wire logic config_mismatch_evt,        // Configuration mismatch pulse
    input wire logic sw_reset_instr_evt,         // Reset instruction pulse
    input wire logic watchdog_timeout_evt,       // Watchdog expiry pulse
    input wire logic brownout_evt,               // Brown-out reset pulse
    input wire logic power_save_instruction,     // Power-save instruction pulse
    input wire logic power_save_idle,            // With the pulse: high idle, low sleep
    input wire logic master_clear_pin,           // External reset pin, active low
    input wire logic [1:0] watchdog_config_field, // Watchdog configuration field
    output logic sw_brownout_enable,             // Software brown-out enable
    output logic retention_sleep_enable,         // Retention regulator in sleep
    output logic progmem_sleep_power,            // Program memory biased in sleep
    output logic watchdog_enable,                // Effective watchdog enable
    output logic irq                             // Interrupt, active high level
);

    localparam int unsigned W = rcsf_pkg::REG_W;

    // Elaboration checks: the map reaches 0x8 and every field constant is 16 bits
    if (ADDR_W < 4 || ADDR_W > 16)
    begin
        $error("rcsf_top: ADDR_W must lie between 4 and 16");
    end
    if (W != 16)
    begin
        $error("rcsf_top: register width must be 16");
    end

    // Byte strobes of the low half word as a bit mask
    function automatic logic [15:0] lane_mask(input logic [3:0] strb);
        lane_mask = {{8{strb[1]}}, {8{strb[0]}}};
    endfunction

    // Byte-lane merge of write data into a stored value
    function automatic logic [15:0] merge_lanes(input logic [15:0] old, input logic [15:0] wd,
        input logic [15:0] m);
        merge_lanes = (old & ~m) | (wd & m);
    endfunction

    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
        addr_hit = (a == ADDR_W'(off));
    endfunction

    logic pin_fall;

    rcsf_sync #(
        .IDLE_LEVEL(1'b1)
    ) u_pin_sync (
        .clk(clk),
        .rstn(rstn),
        .pin(master_clear_pin),
        .level(),
        .fall(pin_fall)
    );

    // Bus handshake and decode
    logic access;
    logic done;
    logic sel_cause;
    logic sel_status;
    logic sel_mask;
    logic mapped;
    logic wr_cause;
    logic wr_mask;
    logic rd_status;
    logic [15:0] wmask;

    logic pready_q;
    logic pready_d;
    logic pslverr_q;
    logic pslverr_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic [15:0] rd_clr_q;
    logic [15:0] rd_clr_d;

    logic [15:0] cause_q;
    logic [15:0] cause_d;
    logic [15:0] hw_set;
    logic [15:0] hw_clr;
    logic [15:0] evt_vec;
    logic sleep_entry;
    logic idle_entry;
    logic wdt_en_q;
    logic wdt_en_d;

    logic [15:0] int_status;
    logic [15:0] int_mask;
    logic [15:0] mask_wd;

    always_comb
    begin
        access = psel & penable;
        // The access phase lasts two cycles: pready rises one cycle in
        done = access & pready_q;
        sel_cause = 1'b0;
        sel_status = 1'b0;
        sel_mask = 1'b0;
        if (addr_hit(paddr, rcsf_pkg::OFF_RESET_CAUSE))
            sel_cause = 1'b1;
        else if (addr_hit(paddr, rcsf_pkg::OFF_INT_STATUS))
            sel_status = 1'b1;
        else if (addr_hit(paddr, rcsf_pkg::OFF_INT_MASK))
            sel_mask = 1'b1;
        mapped = sel_cause | sel_status | sel_mask;
        wmask = lane_mask(pstrb);
        wr_cause = done & pwrite & sel_cause;
        wr_mask = done & pwrite & sel_mask;
        rd_status = done & ~pwrite & sel_status;
    end

    always_comb
    begin
        pready_d = access & ~pready_q;
        pslverr_d = pslverr_q;
        prdata_d = prdata_q;
        rd_clr_d = rd_clr_q;
        if (access & ~pready_q)
        begin
            pslverr_d = ~mapped;
            prdata_d = 32'h0000_0000;
            rd_clr_d = 16'h0000;
            if (!pwrite)
            begin
                if (sel_cause)
                    prdata_d = {16'h0000, cause_q & rcsf_pkg::RESET_CAUSE_WMASK};
                else if (sel_status)
                begin
                    prdata_d = {16'h0000, int_status};
                    // Only the bits software saw are cleared, later events stay
                    rd_clr_d = int_status;
                end
                else if (sel_mask)
                    prdata_d = {16'h0000, int_mask};
            end
        end
        else if (done)
        begin
            pslverr_d = 1'b0;
            rd_clr_d = 16'h0000;
        end
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            rd_clr_q <= 16'h0000;
        end
        else
        begin
            pready_q <= pready_d;
            pslverr_q <= pslverr_d;
            prdata_q <= prdata_d;
            rd_clr_q <= rd_clr_d;
        end
    end

    // Hardware events mapped onto their flag positions
    always_comb
    begin
        sleep_entry = power_save_instruction & ~power_save_idle;
        idle_entry = power_save_instruction & power_save_idle;
        hw_set = 16'h0000;
        hw_set[rcsf_pkg::BIT_TRAP_CONFLICT] = trap_conflict_evt;
        hw_set[rcsf_pkg::BIT_ILLEGAL_INSTR] = illegal_instr_evt;
        hw_set[rcsf_pkg::BIT_CONFIG_MISMATCH] = config_mismatch_evt;
        hw_set[rcsf_pkg::BIT_EXT_PIN_RESET] = pin_fall;
        hw_set[rcsf_pkg::BIT_SW_RESET_INSTR] = sw_reset_instr_evt;
        hw_set[rcsf_pkg::BIT_WATCHDOG_TIMEOUT] = watchdog_timeout_evt;
        hw_set[rcsf_pkg::BIT_SLEEP_WAKE] = sleep_entry;
        hw_set[rcsf_pkg::BIT_IDLE_WAKE] = idle_entry;
        hw_set[rcsf_pkg::BIT_BROWNOUT] = brownout_evt;
        evt_vec = hw_set & rcsf_pkg::EVENT_BITS;
        hw_clr = 16'h0000;
        hw_clr[rcsf_pkg::BIT_WATCHDOG_TIMEOUT] = power_save_instruction;
    end

    always_comb
    begin
        cause_d = cause_q;
        if (wr_cause)
            cause_d = merge_lanes(cause_q, pwdata[15:0], wmask);
        // Hardware clears act after the software write
        cause_d = cause_d & ~hw_clr;
        // A hardware set wins over any clear in the same cycle
        cause_d = cause_d | hw_set;
        cause_d = cause_d & rcsf_pkg::RESET_CAUSE_WMASK;
        wdt_en_d = (watchdog_config_field == rcsf_pkg::WDT_CFG_UNPROGRAMMED)
            | cause_d[rcsf_pkg::BIT_SW_WATCHDOG_EN];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cause_q <= rcsf_pkg::RESET_CAUSE_RST;
            wdt_en_q <= rcsf_pkg::WDT_EN_RST;
        end
        else
        begin
            cause_q <= cause_d;
            wdt_en_q <= wdt_en_d;
        end
    end

    always_comb
    begin
        mask_wd = merge_lanes(int_mask, pwdata[15:0] & rcsf_pkg::EVENT_BITS, wmask);
    end

    rcsf_irq #(
        .W(W)
    ) u_irq (
        .clk(clk),
        .rstn(rstn),
        .evt(evt_vec),
        .rd_clr(rd_clr_q & {16{rd_status}}),
        .mask_we(wr_mask),
        .mask_wd(mask_wd),
        .status(int_status),
        .mask(int_mask),
        .irq(irq)
    );

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign sw_brownout_enable = cause_q[rcsf_pkg::BIT_SW_BROWNOUT_EN];
    assign retention_sleep_enable = cause_q[rcsf_pkg::BIT_RETENTION_SLEEP];
    assign progmem_sleep_power = cause_q[rcsf_pkg::BIT_PROGMEM_SLEEP];
    assign watchdog_enable = wdt_en_q;

endmodule

// ==== verif/rcsf_top_assertions.sv ====
// Port-level checks for the reset-cause status block
`timescale 1ns/10ps
module rcsf_top_assertions #(
    parameter int unsigned ADDR_W = 12
) (
    input wire logic clk, // System clock
    input wire logic rstn, // Power-on reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [ADDR_W-1:0] paddr, // APB address
    input wire logic [31:0] prdata, // APB read data
    input wire logic pready, // APB ready
    input wire logic pslverr, // APB error
    input wire logic [1:0] watchdog_config_field, // Watchdog configuration
    input wire logic watchdog_enable, // Effective watchdog enable
    input wire logic irq // Interrupt level
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_access;
        psel && penable && !pready;
    endsequence
    sequence s_acc_at(logic [ADDR_W-1:0] a);
        psel && penable && !pready && paddr == a;
    endsequence

    a_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    a_ready_wait: assert property (s_access |=> pready)
        else $error("access phase not two cycles");
    a_ready_in_access: assert property (pready |-> psel && penable)
        else $error("pready outside access phase");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    a_unmapped_err: assert property (s_acc_at(12'h00C) |=> pslverr)
        else $error("unmapped address not refused");
    a_mapped_ok: assert property (s_acc_at(12'h000) |=> pready && !pslverr)
        else $error("mapped address refused");
    a_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("upper read bits not zero");
    a_gap_zero: assert property (pready && !pwrite && paddr == 12'h000 |-> prdata[11:10] == 2'h0)
        else $error("unimplemented bits not zero");
    a_wdt_forced: assert property (watchdog_config_field == 2'h3 |=> watchdog_enable)
        else $error("watchdog not forced on");
    a_irq_quiet: assert property ($rose(rstn) |-> !irq)
        else $error("irq high after reset");
endmodule

bind rcsf_top rcsf_top_assertions #(.ADDR_W(ADDR_W)) u_chk (.clk(clk), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_config_field(watchdog_config_field),
    .watchdog_enable(watchdog_enable), .irq(irq));

// ==== verif/test_reset_cause_status_flags.sv ====
// Self-checking bench for the reset-cause status block
`timescale 1ns/10ps
module test_reset_cause_status_flags;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, psi = 1'b0, psidle = 1'b0, mcp = 1'b1, bo, rs, pm, we, irq;
    logic [5:0] evts = 6'h00;
    logic [1:0] wcf = 2'h3;
    int bad_count = 0, checks_done = 0;
    // Flag positions for evts[5] down to evts[0]
    localparam int BITPOS [6] = '{15, 14, 9, 6, 4, 1};

    always #20 clk = ~clk;

    rcsf_top #(.ADDR_W(12)) uut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .trap_conflict_evt(evts[5]),
        .illegal_instr_evt(evts[4]), .config_mismatch_evt(evts[3]),
        .sw_reset_instr_evt(evts[2]), .watchdog_timeout_evt(evts[1]),
        .brownout_evt(evts[0]), .power_save_instruction(psi), .power_save_idle(psidle),
        .master_clear_pin(mcp), .watchdog_config_field(wcf), .sw_brownout_enable(bo),
        .retention_sleep_enable(rs), .progmem_sleep_power(pm), .watchdog_enable(we),
        .irq(irq));

    task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Setup, access, wait for pready, take data at that edge, release
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        chk("pready", 32'h1, {31'h0, pready});
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(what, exp, rd);
    endtask

    task pulse(input logic [5:0] e, input logic p, input logic idle);
        @(posedge clk);
        evts <= e;
        psi <= p;
        psidle <= idle;
        @(posedge clk);
        evts <= 6'h00;
        psi <= 1'b0;
    endtask

    task t_reset;
        rdchk("reset value", 12'h000, 32'h0000_0003);
        chk("wdt enable", 32'h1, {31'h0, we});
    endtask

    task t_irq;
        apb(1'b1, 12'h008, 32'h0000_FFFF);
        rdchk("mask", 12'h008, 32'h0000_C2DE);
        pulse(6'h20, 1'b0, 1'b0);
        @(negedge clk);
        chk("irq raised", 32'h1, {31'h0, irq});
        rdchk("status", 12'h004, 32'h0000_8000);
        @(negedge clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        apb(1'b1, 12'h008, 32'h0);
        pulse(6'h20, 1'b0, 1'b0);
        @(negedge clk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdchk("status masked", 12'h004, 32'h0000_8000);
    endtask

    task t_events;
        for (int i = 0; i < 6; i++)
        begin
            apb(1'b1, 12'h000, 32'h0);
            pulse(6'h20 >> i, 1'b0, 1'b0);
            rdchk("event flag", 12'h000, 32'h1 << BITPOS[i]);
        end
        apb(1'b1, 12'h000, 32'h0);
        @(posedge clk);
        mcp <= 1'b0;
        repeat (6) @(posedge clk);
        rdchk("pin flag", 12'h000, 32'h0000_0080);
        mcp <= 1'b1;
    endtask

    task t_psave;
        apb(1'b1, 12'h000, 32'h0);
        pulse(6'h02, 1'b0, 1'b0);
        pulse(6'h00, 1'b1, 1'b0);
        rdchk("sleep entry", 12'h000, 32'h0000_0008);
        apb(1'b1, 12'h000, 32'h0);
        pulse(6'h02, 1'b1, 1'b1);
        rdchk("idle entry", 12'h000, 32'h0000_0014);
    endtask

    task t_soft;
        apb(1'b1, 12'h000, 32'h0000_FFFF);
        rdchk("sw set", 12'h000, 32'h0000_F3FF);
        chk("ctrl outs", 32'h7, {29'h0, bo, rs, pm});
        apb(1'b1, 12'h000, 32'h0);
        rdchk("sw clear", 12'h000, 32'h0);
        wcf <= 2'h0;
        repeat (2) @(posedge clk);
        chk("wdt off", 32'h0, {31'h0, we});
        apb(1'b1, 12'h000, 32'h0000_0020);
        @(posedge clk);
        chk("wdt sw on", 32'h1, {31'h0, we});
        apb(1'b1, 12'h000, 32'h0);
        wcf <= 2'h3;
        repeat (2) @(posedge clk);
        chk("wdt forced", 32'h1, {31'h0, we});
    endtask

    task t_unmapped;
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
    endtask

    task stop_test;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    initial
    begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        t_reset();
        t_irq();
        t_events();
        t_psave();
        t_soft();
        t_unmapped();
        stop_test();
    end

    // The tests need well under a thousand cycles
    initial
    begin
        #200000;
        bad_count++;
        stop_test();
    end
endmodule
